// file: core/cks_clock_ctrl.sv
// cks_clock_ctrl: clock source select, start-up sequencer and trim register
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ps
`default_nettype none
module cks_clock_ctrl #(
    parameter int ADDR_W = 12,
    parameter int SHORT_TICKS = cks_pkg::RST_SHORT_TICKS,
    parameter int LONG_TICKS = cks_pkg::RST_LONG_TICKS
) (
    input wire logic clk, // 125 MHz system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic [ADDR_W-1:0] s_axi_awaddr, // write address
    input wire logic s_axi_awvalid, // write address valid
    output logic s_axi_awready, // write address ready
    input wire logic [31:0] s_axi_wdata, // write data
    input wire logic [3:0] s_axi_wstrb, // write strobes
    input wire logic s_axi_wvalid, // write data valid
    output logic s_axi_wready, // write data ready
    output logic [1:0] s_axi_bresp, // write response
    output logic s_axi_bvalid, // write response valid
    input wire logic s_axi_bready, // write response ready
    input wire logic [ADDR_W-1:0] s_axi_araddr, // read address
    input wire logic s_axi_arvalid, // read address valid
    output logic s_axi_arready, // read address ready
    output logic [31:0] s_axi_rdata, // read data
    output logic [1:0] s_axi_rresp, // read response
    output logic s_axi_rvalid, // read data valid
    input wire logic s_axi_rready, // read data ready
    input wire logic [7:0] factoryCal, // factory calibration byte
    input wire logic oscInputPin, // external clock pin
    input wire logic rcOscClk, // internal rc oscillator output
    input wire logic wdtOscClk, // watchdog oscillator output
    input wire logic sleepReq, // pulse: enter power-down
    input wire logic wakeReq, // pulse: wake from power-down
    output logic coreClkEn, // core clock released
    output logic clkSrcExt, // external pin drives the core
    output logic rcEnable, // rc oscillator enabled
    output logic [1:0] rcRange, // rc nominal range 1/2/4/8 MHz
    output logic [7:0] oscTrim, // trim value to rc oscillator
    output logic [7:0] tunePct // estimated percent of nominal
);
    localparam int DLY_W = $clog2(LONG_TICKS + 1);

    // refuse widths and counts the logic cannot serve
    if (ADDR_W <= 4 || ADDR_W > 32 || SHORT_TICKS < 1 || LONG_TICKS < SHORT_TICKS) begin : g_chk
        $error("cks_clock_ctrl parameter out of range");
    end

    // pin synchronisers: 0 external pin, 1 rc, 2 watchdog
    logic [2:0] pinsIn;
    logic [2:0] pinsRise;
    assign pinsIn = {wdtOscClk, rcOscClk, oscInputPin};
    for (genvar i = 0; i < 3; i++) begin : g_sync
        cks_edge_sync #(.STAGES(2)) u_sync (
            .clk(clk),
            .rst_n(rst_n),
            .pinIn(pinsIn[i]),
            .level(),
            .rise(pinsRise[i])
        );
    end

    // register decode shared by read and write
    function automatic logic [1:0] regSel(input logic [ADDR_W-1:0] a);
        regSel = cks_pkg::SEL_NONE;
        if (a[ADDR_W-1:4] == '0) begin
            case (a[3:0])
                cks_pkg::OFS_TRIM: regSel = cks_pkg::SEL_TRIM;
                cks_pkg::OFS_CFG: regSel = cks_pkg::SEL_CFG;
                cks_pkg::OFS_STATUS: regSel = cks_pkg::SEL_STATUS;
                default: regSel = cks_pkg::SEL_NONE;
            endcase
        end
    endfunction : regSel

    // bus state
    logic awHave_q, awHave_d; // write address held
    logic [ADDR_W-1:0] awAddr_q, awAddr_d;
    logic wHave_q, wHave_d; // write data held
    logic [31:0] wData_q, wData_d;
    logic wStrb0_q, wStrb0_d; // low byte lane strobe
    logic bvalid_q, bvalid_d;
    logic [1:0] bresp_q, bresp_d;
    logic rvalid_q, rvalid_d;
    logic [1:0] rresp_q, rresp_d;
    logic [31:0] rdata_q, rdata_d;
    // software-visible state
    logic [7:0] trim_q, trim_d; // trim register
    cks_pkg::cks_fuse_s cfg_q, cfg_d; // fuse image for next wake
    logic [7:0] pct_q, pct_d; // percent-of-nominal estimate
    // start-up sequencer state
    cks_pkg::cks_state_e state_q, state_d;
    cks_pkg::cks_fuse_s act_q, act_d; // configuration in force
    logic [2:0] ckCnt_q, ckCnt_d; // new-clock cycle count
    logic [DLY_W-1:0] dlyCnt_q, dlyCnt_d; // watchdog tick count
    logic srcTick; // edge of selected source
    logic wdtTick; // edge of watchdog oscillator
    logic [DLY_W-1:0] dlyLast; // last delay count
    logic [31:0] statusWord;

    // source decode from active configuration
    assign clkSrcExt = (act_q.source == cks_pkg::SRC_EXT);
    assign rcEnable = !clkSrcExt;
    assign rcRange = (act_q.source >= cks_pkg::SRC_RC1 && act_q.source <= cks_pkg::SRC_RC8)
        ? 2'(act_q.source - cks_pkg::SRC_RC1) : 2'h0;
    assign srcTick = clkSrcExt ? pinsRise[0] : pinsRise[1];
    assign wdtTick = pinsRise[2];
    assign dlyLast = (act_q.startup == cks_pkg::SUT_SHORT) ? DLY_W'(SHORT_TICKS - 1)
        : DLY_W'(LONG_TICKS - 1);
    assign coreClkEn = (state_q == cks_pkg::ST_RUN);
    assign oscTrim = trim_q;
    assign tunePct = pct_q;

    // status word assembly
    always_comb begin
        statusWord = 32'h0000_0000;
        statusWord[cks_pkg::ST_BIT_RUN] = coreClkEn;
        statusWord[cks_pkg::ST_BIT_EXT] = clkSrcExt;
        statusWord[cks_pkg::ST_BIT_RSVD] = (act_q.startup == cks_pkg::SUT_RSVD);
        statusWord[cks_pkg::ST_BIT_STATE +: 3] = state_q;
        statusWord[cks_pkg::ST_BIT_PCT +: 8] = pct_q;
    end

    // bus next values: write and read channels
    always_comb begin
        awHave_d = awHave_q;
        awAddr_d = awAddr_q;
        wHave_d = wHave_q;
        wData_d = wData_q;
        wStrb0_d = wStrb0_q;
        bvalid_d = bvalid_q;
        bresp_d = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d = rresp_q;
        rdata_d = rdata_q;
        trim_d = trim_q;
        cfg_d = cfg_q;
        // take address and data in either order
        if (s_axi_awvalid && s_axi_awready) begin
            awHave_d = 1'b1;
            awAddr_d = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            wHave_d = 1'b1;
            wData_d = s_axi_wdata;
            wStrb0_d = s_axi_wstrb[0];
        end
        // both halves held: commit and respond
        if (awHave_q && wHave_q) begin
            awHave_d = 1'b0;
            wHave_d = 1'b0;
            bvalid_d = 1'b1;
            bresp_d = cks_pkg::RESP_OKAY;
            case (regSel(awAddr_q))
                cks_pkg::SEL_TRIM: if (wStrb0_q) trim_d = wData_q[7:0];
                cks_pkg::SEL_CFG: if (wStrb0_q) cfg_d = wData_q[cks_pkg::CFG_W-1:0];
                cks_pkg::SEL_STATUS: ; // read-only, write ignored
                default: bresp_d = cks_pkg::RESP_SLVERR;
            endcase
        end
        if (s_axi_bvalid && s_axi_bready) begin
            bvalid_d = 1'b0;
        end
        // read: answer next cycle
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_d = 1'b1;
            rresp_d = cks_pkg::RESP_OKAY;
            case (regSel(s_axi_araddr))
                cks_pkg::SEL_TRIM: rdata_d = {24'h00_0000, trim_q};
                cks_pkg::SEL_CFG: rdata_d = {25'h000_0000, cfg_q};
                cks_pkg::SEL_STATUS: rdata_d = statusWord;
                default: begin
                    rdata_d = 32'h0000_0000;
                    rresp_d = cks_pkg::RESP_SLVERR;
                end
            endcase
        end else if (s_axi_rvalid && s_axi_rready) begin
            rvalid_d = 1'b0;
        end
        // monotone trim to frequency estimate
        pct_d = 8'(cks_pkg::TRIM_PCT_MIN + (int'(trim_q) * cks_pkg::TRIM_PCT_SPAN)
            / cks_pkg::TRIM_MAX);
    end

    assign s_axi_awready = !awHave_q && !bvalid_q;
    assign s_axi_wready = !wHave_q && !bvalid_q;
    assign s_axi_bvalid = bvalid_q;
    assign s_axi_bresp = bresp_q;
    assign s_axi_arready = !rvalid_q;
    assign s_axi_rvalid = rvalid_q;
    assign s_axi_rresp = rresp_q;
    assign s_axi_rdata = rdata_q;

    // start-up sequencer next values
    always_comb begin
        state_d = state_q;
        act_d = act_q;
        ckCnt_d = ckCnt_q;
        dlyCnt_d = dlyCnt_q;
        case (state_q)
            cks_pkg::ST_COUNT, cks_pkg::ST_WAKE: begin
                // count cycles of the newly running clock
                if (srcTick) begin
                    if (ckCnt_q == 3'(cks_pkg::STARTUP_CK - 1)) begin
                        ckCnt_d = 3'h0;
                        dlyCnt_d = '0;
                        // reset delay only after reset, never after wake
                        if (state_q == cks_pkg::ST_WAKE || act_q.startup == cks_pkg::SUT_NONE)
                            state_d = cks_pkg::ST_RUN;
                        else
                            state_d = cks_pkg::ST_DELAY;
                    end else begin
                        ckCnt_d = ckCnt_q + 3'h1;
                    end
                end
            end
            cks_pkg::ST_DELAY: begin
                // wait out the reset delay on watchdog ticks
                if (wdtTick) begin
                    if (dlyCnt_q == dlyLast) state_d = cks_pkg::ST_RUN;
                    else dlyCnt_d = dlyCnt_q + DLY_W'(1);
                end
            end
            cks_pkg::ST_RUN: if (sleepReq) state_d = cks_pkg::ST_SLEEP;
            cks_pkg::ST_SLEEP: begin
                // wake picks up the configuration written since reset
                if (wakeReq) begin
                    state_d = cks_pkg::ST_WAKE;
                    act_d = cfg_q;
                    ckCnt_d = 3'h0;
                end
            end
            default: state_d = cks_pkg::ST_COUNT;
        endcase
    end

    // registers; reset loads factory fuses and calibration byte
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            awHave_q <= 1'b0;
            awAddr_q <= '0;
            wHave_q <= 1'b0;
            wData_q <= 32'h0000_0000;
            wStrb0_q <= 1'b0;
            bvalid_q <= 1'b0;
            bresp_q <= cks_pkg::RESP_OKAY;
            rvalid_q <= 1'b0;
            rresp_q <= cks_pkg::RESP_OKAY;
            rdata_q <= 32'h0000_0000;
            trim_q <= factoryCal;
            cfg_q <= cks_pkg::FUSE_FACTORY;
            pct_q <= 8'h00;
            state_q <= cks_pkg::ST_COUNT;
            act_q <= cks_pkg::FUSE_FACTORY;
            ckCnt_q <= 3'h0;
            dlyCnt_q <= '0;
        end else begin
            awHave_q <= awHave_d;
            awAddr_q <= awAddr_d;
            wHave_q <= wHave_d;
            wData_q <= wData_d;
            wStrb0_q <= wStrb0_d;
            bvalid_q <= bvalid_d;
            bresp_q <= bresp_d;
            rvalid_q <= rvalid_d;
            rresp_q <= rresp_d;
            rdata_q <= rdata_d;
            trim_q <= trim_d;
            cfg_q <= cfg_d;
            pct_q <= pct_d;
            state_q <= state_d;
            act_q <= act_d;
            ckCnt_q <= ckCnt_d;
            dlyCnt_q <= dlyCnt_d;
        end
    end

    // checks on the sequencer and trim path
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    sequence s_last_ck;
        (state_q == cks_pkg::ST_COUNT || state_q == cks_pkg::ST_WAKE) && srcTick
            && ckCnt_q == 3'(cks_pkg::STARTUP_CK - 1);
    endsequence
    sequence s_wake_last;
        state_q == cks_pkg::ST_WAKE ##0 s_last_ck;
    endsequence

    // reset itself is the trigger here, so the default disable is switched off
    property p_trim_load;
        disable iff (1'b0) $rose(rst_n) |-> trim_q == $past(factoryCal);
    endproperty
    a_trim_load: assert property (p_trim_load)
        else $error("trim not loaded from calibration byte");
    property p_factory_cfg;
        disable iff (1'b0) $rose(rst_n) |-> act_q == cks_pkg::FUSE_FACTORY && rcEnable
            && rcRange == 2'h0;
    endproperty
    a_factory_cfg: assert property (p_factory_cfg)
        else $error("factory configuration not in force after reset");
    property p_rc_range;
        act_q.source == 4'h4 |-> rcEnable && !clkSrcExt && rcRange == 2'h3;
    endproperty
    a_rc_range: assert property (p_rc_range)
        else $error("code 0100 does not select the 8 MHz range");
    property p_ext_sel;
        act_q.source == 4'h0 |-> clkSrcExt && !rcEnable;
    endproperty
    a_ext_sel: assert property (p_ext_sel)
        else $error("code 0000 does not select the external pin");
    property p_trim_ends;
        trim_q == 8'hFF ##1 trim_q == 8'hFF |-> pct_q == 8'hC8;
    endproperty
    a_trim_ends: assert property (p_trim_ends)
        else $error("full trim does not give the top of range");
    property p_trim_mid;
        trim_q == 8'h7F ##1 trim_q == 8'h7F |-> pct_q >= 8'h4B && pct_q <= 8'h96;
    endproperty
    a_trim_mid: assert property (p_trim_mid)
        else $error("mid trim outside 75 to 150 percent");
    property p_wake_release;
        s_wake_last |=> coreClkEn;
    endproperty
    a_wake_release: assert property (p_wake_release)
        else $error("wake did not release after six cycles");
    // external source on wake: release right after the sixth pin edge, no extra wait
    property p_no_extra;
        state_q == cks_pkg::ST_WAKE && act_q.source == cks_pkg::SRC_EXT ##0 s_last_ck
            |=> coreClkEn && clkSrcExt;
    endproperty
    a_no_extra: assert property (p_no_extra)
        else $error("external start-up added a delay");
    // delay entered only on the sixth source edge, counter cleared
    property p_delay_hold;
        state_q == cks_pkg::ST_COUNT ##1 state_q == cks_pkg::ST_DELAY |-> !coreClkEn
            && dlyCnt_q == '0 && $past(srcTick)
            && $past(ckCnt_q) == 3'(cks_pkg::STARTUP_CK - 1);
    endproperty
    a_delay_hold: assert property (p_delay_hold)
        else $error("core released before reset delay");
    property p_wdt_only;
        state_q == cks_pkg::ST_DELAY && !wdtTick |=> $stable(dlyCnt_q) && !coreClkEn;
    endproperty
    a_wdt_only: assert property (p_wdt_only)
        else $error("reset delay advanced without watchdog tick");
    // factory long delay: release on the last watchdog tick
    property p_long_delay;
        state_q == cks_pkg::ST_DELAY && act_q.startup == cks_pkg::SUT_LONG && wdtTick
            && dlyCnt_q == DLY_W'(LONG_TICKS - 1) |=> coreClkEn;
    endproperty
    a_long_delay: assert property (p_long_delay)
        else $error("long reset delay wrong length");
    // no release before the long count is reached
    property p_delay_early;
        state_q == cks_pkg::ST_DELAY && act_q.startup != cks_pkg::SUT_SHORT
            && dlyCnt_q != DLY_W'(LONG_TICKS - 1) |=> !coreClkEn;
    endproperty
    a_delay_early: assert property (p_delay_early)
        else $error("core released before reset delay ran out");
endmodule : cks_clock_ctrl
`default_nettype wire

// file: core/cks_pkg.sv
// cks_pkg: constants, types and states of the clock source select and trim block
// Function
// - RC codes 0001..0100 give 1/2/4/8 MHz
// - factory default: RC 1 MHz, start-up code 10
// - reset copies calibration byte into trim register
// - trim sets RC frequency monotonically, 00 lowest
// - trim 00/7F/FF span 50-100/75-150/100-200 percent
// - RC start-up 6 CK plus none/4.1/65 ms; reset reloads code 10, so always 65 ms after reset, none after wake
// - source code 0000 selects external clock pin
// - external start-up 6 CK plus none/4.1/65 ms; the pin is put in force only by a wake, so 6 CK and no delay
// - watchdog oscillator times the reset delay
// - power-down wake waits only the 6 CK start-up, never the reset delay
package cks_pkg;
    // register byte offsets on the AXI4-Lite slave
    localparam logic [3:0] OFS_TRIM = 4'h0;
    localparam logic [3:0] OFS_CFG = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    // decoded register selector
    localparam logic [1:0] SEL_TRIM = 2'h0;
    localparam logic [1:0] SEL_CFG = 2'h1;
    localparam logic [1:0] SEL_STATUS = 2'h2;
    localparam logic [1:0] SEL_NONE = 2'h3;
    // axi responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    // clock source select codes
    localparam logic [3:0] SRC_EXT = 4'h0;
    localparam logic [3:0] SRC_RC1 = 4'h1;
    localparam logic [3:0] SRC_RC8 = 4'h4;
    // start-up time codes
    localparam logic [1:0] SUT_NONE = 2'h0;
    localparam logic [1:0] SUT_SHORT = 2'h1;
    localparam logic [1:0] SUT_LONG = 2'h2;
    localparam logic [1:0] SUT_RSVD = 2'h3;
    // start-up cycles of the newly running clock
    localparam int STARTUP_CK = 6;
    // extra reset delays and nominal watchdog oscillator rate
    localparam real RST_SHORT_MS = 4.1;
    localparam real RST_LONG_MS = 65.0;
    localparam real WDT_OSC_MHZ = 1.0;
    localparam int RST_SHORT_TICKS = int'($ceil(RST_SHORT_MS * 1000.0 * WDT_OSC_MHZ));
    localparam int RST_LONG_TICKS = int'($ceil(RST_LONG_MS * 1000.0 * WDT_OSC_MHZ));
    // trim to percent-of-nominal mapping
    localparam int TRIM_PCT_MIN = 50;
    localparam int TRIM_PCT_SPAN = 150;
    localparam int TRIM_MAX = 255;
    // status bit positions
    localparam int ST_BIT_RUN = 0;
    localparam int ST_BIT_EXT = 1;
    localparam int ST_BIT_RSVD = 2;
    localparam int ST_BIT_STATE = 4;
    localparam int ST_BIT_PCT = 8;
    // fuse image: option fuse, start-up code, source code
    typedef struct packed {
        logic optFuse; // 1 = unprogrammed
        logic [1:0] startup; // start-up time code
        logic [3:0] source; // clock source code
    } cks_fuse_s;
    localparam int CFG_W = 7;
    localparam cks_fuse_s FUSE_FACTORY = '{optFuse: 1'b1, startup: SUT_LONG, source: SRC_RC1};
    // start-up states, gray along count, delay, run, sleep, wake
    typedef enum logic [2:0] {
        ST_COUNT = 3'b000,
        ST_DELAY = 3'b001,
        ST_RUN = 3'b011,
        ST_SLEEP = 3'b010,
        ST_WAKE = 3'b110
    } cks_state_e;
endpackage : cks_pkg

// file: core/cks_edge_sync.sv
// cks_edge_sync: two-stage pin synchroniser with rising edge pulse
`timescale 1ns/1ps
`default_nettype none
module cks_edge_sync #(
    parameter int STAGES = 2
) (
    input wire logic clk, // system clock
    input wire logic rst_n, // synchronous reset, active low
    input wire logic pinIn, // asynchronous pin level
    output logic level, // synchronised level
    output logic rise // one-cycle pulse on rising edge
);
    logic [STAGES-1:0] sync_q; // synchroniser chain
    logic [STAGES-1:0] sync_d;
    logic prev_q; // last synchronised level
    logic prev_d;

    // refuse chains too short to settle
    if (STAGES < 2) begin : g_chk
        $error("cks_edge_sync needs at least two stages");
    end

    // next values: shift the pin in
    always_comb begin
        sync_d = {sync_q[STAGES-2:0], pinIn};
        prev_d = sync_q[STAGES-1];
    end

    // registers only
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync_q <= '0;
            prev_q <= 1'b0;
        end else begin
            sync_q <= sync_d;
            prev_q <= prev_d;
        end
    end

    // only the last stage feeds logic
    assign level = sync_q[STAGES-1];
    assign rise = sync_q[STAGES-1] & ~prev_q;
endmodule : cks_edge_sync
`default_nettype wire

// file: tb/cks_osc_model.sv
// cks_osc_model: external clock source, rc and watchdog oscillator models
`timescale 1ns/1ps
`default_nettype none
module cks_osc_model #(
    parameter int EXT_HALF_NS = 24,
    parameter int RC_HALF_NS = 32,
    parameter int WDT_HALF_NS = 40
) (
    input wire logic rcEnable, // rc oscillator enable from the block
    output logic oscInputPin, // external clock pin drive
    output logic rcOscClk, // rc oscillator output
    output logic wdtOscClk // watchdog oscillator output
);
    // external source: fixed period, no step between cycles
    initial begin
        oscInputPin = 1'b0;
        forever #(EXT_HALF_NS) oscInputPin = ~oscInputPin;
    end
    // rc output parked low while disabled
    initial begin
        rcOscClk = 1'b0;
        forever #(RC_HALF_NS) rcOscClk = rcEnable ? ~rcOscClk : 1'b0;
    end
    // watchdog oscillator runs free from power-up
    initial begin
        wdtOscClk = 1'b0;
        forever #(WDT_HALF_NS) wdtOscClk = ~wdtOscClk;
    end
endmodule : cks_osc_model
`default_nettype wire

// file: tb/cks_clock_ctrl_bench.sv
// cks_clock_ctrl_bench: self-checking bench of the clock source block
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, a) begin totalChecks++; if ((a) !== (e)) begin numErrors++; \
    $display("BAD %s exp %h seen %h", nm, e, a); end end
module cks_clock_ctrl_bench;
    logic clk = 1'b0, rst_n = 1'b0; // clock and reset
    logic [11:0] awAddr = 12'h0, arAddr = 12'h0; // bus addresses
    logic awValid = 1'b0, wValid = 1'b0, bReady = 1'b0, arValid = 1'b0, rReady = 1'b0;
    logic [31:0] wData = 32'h0; // write data
    logic [3:0] wStrb = 4'hF; // write strobes
    logic awReady, wReady, bValid, arReady, rValid; // slave handshakes
    logic [1:0] bResp, rResp; // responses
    logic [31:0] rData; // read data
    logic [7:0] factoryCal = 8'h00; // calibration byte
    logic sleepReq = 1'b0, wakeReq = 1'b0; // sequencer requests
    logic coreClkEn, clkSrcExt, rcEnable; // clock status
    logic [1:0] rcRange; // rc range
    logic [7:0] oscTrim, tunePct; // trim and estimate
    logic oscInputPin, rcOscClk, wdtOscClk; // oscillator lines
    logic [33:0] rdQ[$]; // expected read response and data
    logic [1:0] wrQ[$]; // expected write responses
    logic [33:0] rdExp; // popped read note
    logic [1:0] wrExp; // popped write note
    int numErrors = 0, totalChecks = 0, n; // counters
    integer seed = 32'h96CB; // random seed
    logic [7:0] curTrim; // trim the bench believes is loaded
    logic [31:0] cfg; // config word under test
    // 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end
    cks_osc_model osc_u (.rcEnable(rcEnable), .oscInputPin(oscInputPin),
        .rcOscClk(rcOscClk), .wdtOscClk(wdtOscClk));
    cks_clock_ctrl #(.ADDR_W(12), .SHORT_TICKS(3), .LONG_TICKS(5)) dut_u (
        .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awAddr), .s_axi_awvalid(awValid),
        .s_axi_awready(awReady), .s_axi_wdata(wData), .s_axi_wstrb(wStrb),
        .s_axi_wvalid(wValid), .s_axi_wready(wReady), .s_axi_bresp(bResp),
        .s_axi_bvalid(bValid), .s_axi_bready(bReady), .s_axi_araddr(arAddr),
        .s_axi_arvalid(arValid), .s_axi_arready(arReady), .s_axi_rdata(rData),
        .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
        .factoryCal(factoryCal), .oscInputPin(oscInputPin), .rcOscClk(rcOscClk),
        .wdtOscClk(wdtOscClk), .sleepReq(sleepReq), .wakeReq(wakeReq),
        .coreClkEn(coreClkEn), .clkSrcExt(clkSrcExt), .rcEnable(rcEnable),
        .rcRange(rcRange), .oscTrim(oscTrim), .tunePct(tunePct));
    // watcher: pops the oldest note whenever a response is handed over
    always @(posedge clk) begin
        if (rValid && rReady) begin
            rdExp = rdQ.pop_front();
            `CHK("read", rdExp, {rResp, rData})
        end
        if (bValid && bReady) begin
            wrExp = wrQ.pop_front();
            `CHK("bresp", wrExp, bResp)
        end
    end
    // one full write, address and data offered together
    task automatic axiWr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] r);
        bit aw, w;
        wrQ.push_back(r);
        aw = 0;
        w = 0;
        awAddr <= a;
        wData <= d;
        awValid <= 1'b1;
        wValid <= 1'b1;
        bReady <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clk);
            if (!aw && awReady) begin aw = 1; awValid <= 1'b0; end
            if (!w && wReady) begin w = 1; wValid <= 1'b0; end
        end
        do @(posedge clk); while (bValid !== 1'b1);
        bReady <= 1'b0;
        @(posedge clk);
    endtask : axiWr
    // one full read with the expected answer noted
    task automatic axiRd(input logic [11:0] a, input logic [33:0] e);
        rdQ.push_back(e);
        arAddr <= a;
        arValid <= 1'b1;
        rReady <= 1'b1;
        do @(posedge clk); while (arReady !== 1'b1);
        arValid <= 1'b0;
        while (rValid !== 1'b1) @(posedge clk);
        rReady <= 1'b0;
        @(posedge clk);
    endtask : axiRd
    // bounded wait for the core clock release, cycles in n
    task automatic waitRun();
        n = 0;
        while (coreClkEn !== 1'b1 && n < 5000) begin @(posedge clk); n++; end
        `CHK("release", 1'b1, coreClkEn)
    endtask : waitRun
    // reset with a fresh calibration byte, then factory checks
    task automatic doRst();
        rst_n <= 1'b0;
        factoryCal <= 8'($random(seed));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        curTrim = factoryCal;
        @(posedge clk);
        `CHK("rcEnable", 1'b1, rcEnable)
        `CHK("rcRange", 2'h0, rcRange)
        waitRun();
        `CHK("rstdelay", 1'b1, n > 70)
        axiRd(12'h000, {cks_pkg::RESP_OKAY, 24'h0, curTrim});
        axiRd(12'h004, {cks_pkg::RESP_OKAY, 32'h61});
    endtask : doRst
    function automatic logic [7:0] pct(input logic [7:0] t);
        return 8'(50 + (int'(t) * 150) / 255);
    endfunction : pct
    // ends the run with the verdict
    task automatic summarize();
        if (numErrors == 0 && totalChecks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : summarize
    // watchdog against hangs
    initial begin
        repeat (20000) @(posedge clk);
        numErrors++;
        summarize();
    end
    // main sequence
    initial begin
        doRst();
        // trim boundaries, a random value, monotonic estimate
        for (int i = 0; i < 4; i++) begin
            curTrim = (i == 0) ? 8'h00 : (i == 1) ? 8'h7F : (i == 2) ? 8'hFF
                : 8'($random(seed));
            // no nonvolatile writes under way, so any trim is allowed
            axiWr(12'h000, {24'h0, curTrim}, cks_pkg::RESP_OKAY);
            `CHK("oscTrim", curTrim, oscTrim)
            `CHK("tunePct", pct(curTrim), tunePct)
        end
        axiRd(12'h000, {cks_pkg::RESP_OKAY, 24'h0, curTrim});
        axiRd(12'h0C0, {cks_pkg::RESP_SLVERR, 32'h0});
        axiWr(12'h0C0, 32'h1, cks_pkg::RESP_SLVERR);
        // every source code and start-up code via sleep and wake
        for (int i = 0; i < 5; i++) begin
            cfg = 32'h40 | ((i % 4) << 4) | i;
            axiWr(12'h004, cfg, cks_pkg::RESP_OKAY);
            axiRd(12'h004, {cks_pkg::RESP_OKAY, cfg});
            sleepReq <= 1'b1;
            @(posedge clk);
            sleepReq <= 1'b0;
            @(posedge clk);
            `CHK("sleep", 1'b0, coreClkEn)
            wakeReq <= 1'b1;
            @(posedge clk);
            wakeReq <= 1'b0;
            waitRun();
            `CHK("wakedelay", 1'b1, n >= 25 && n < 70)
            `CHK("clkSrcExt", i == 0, clkSrcExt)
            `CHK("rcEnable", i != 0, rcEnable)
            `CHK("rcRange", (i == 0) ? 2'h0 : 2'(i - 1), rcRange)
            axiRd(12'h008, {cks_pkg::RESP_OKAY, 16'h0, pct(curTrim), 1'b0,
                cks_pkg::ST_RUN, 1'b0, (i % 4) == 3, i == 0, 1'b1});
        end
        doRst();
        summarize();
    end
endmodule : cks_clock_ctrl_bench
`undef CHK
`default_nettype wire
